// File: rtl/matrix_cmd_pkg.sv
// Constants for the serial command interpreter of the video matrix switch.
// Assumes one 200 MHz system clock and fixed 16x16 routing dimensions.
package matrix_cmd_pkg;
  // Clock and line rates
  localparam int CLK_HZ       = 200_000_000;
  localparam int BAUD_9600    = 9600;
  localparam int BAUD_2400    = 2400;
  localparam int BAUD_1200    = 1200;
  localparam int BAUD_300     = 300;
  localparam int BIT_CYC_9600 = CLK_HZ / BAUD_9600;
  localparam int BIT_CYC_2400 = CLK_HZ / BAUD_2400;
  localparam int BIT_CYC_1200 = CLK_HZ / BAUD_1200;
  localparam int BIT_CYC_300  = CLK_HZ / BAUD_300;
  // Character frame: data bits, then the shift length including stop
  localparam int DATA_BITS    = 8;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  // Rate selector encodings
  localparam logic [1:0] RATE_9600 = 2'h0;
  localparam logic [1:0] RATE_2400 = 2'h1;
  localparam logic [1:0] RATE_1200 = 2'h2;
  localparam logic [1:0] RATE_300  = 2'h3;
  // Rate codes carried by the set_line_rate command
  localparam logic [6:0] CODE_1200 = 7'h0c;
  localparam logic [6:0] CODE_2400 = 7'h18;
  localparam logic [6:0] CODE_9600 = 7'h60;
  // Matrix dimensions and storage
  localparam int NUM_IN   = 16;
  localparam int NUM_OUT  = 16;
  localparam int NUM_BANK = 10;
  localparam int LINE_MAX = 16;
  localparam int RESP_MAX = 8;
  // Characters
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_STAR  = 8'h2a;
  localparam logic [7:0] CH_QM    = 8'h3f;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_NINE  = 8'h39;
  localparam logic [7:0] CH_NUL   = 8'h00;
  // Command letter pairs
  localparam logic [15:0] CMD_CONNECT_ONE = 16'h4353;
  localparam logic [15:0] CMD_CONNECT_ALL = 16'h4341;
  localparam logic [15:0] CMD_QUERY       = 16'h524f;
  localparam logic [15:0] CMD_SAVE        = 16'h4343;
  localparam logic [15:0] CMD_RESTORE     = 16'h5243;
  localparam logic [15:0] CMD_RATE        = 16'h4342;
  localparam logic [15:0] CMD_RESTART     = 16'h5253;
  localparam logic [15:0] CMD_VERSION     = 16'h5256;
  localparam logic [15:0] CMD_DIMS        = 16'h5255;
  // Version text, arbitrary value
  localparam logic [23:0] VERSION_TEXT = 24'h4d5831;
  // Register offsets, field positions and reset values
  localparam logic [3:0] REG_CFG      = 4'h0;
  localparam logic [3:0] REG_STAT     = 4'h4;
  localparam int         CFG_ADDR_LSB = 0;
  localparam int         CFG_RATE_LSB = 4;
  localparam logic [3:0] ADDR_RST     = 4'h1;
  // Controller states
  typedef enum logic [1:0] {ST_RX, ST_PARSE, ST_TX} ctl_state_t;
endpackage

// File: rtl/matrix_serial_command_interpreter.sv
// Serial command interpreter: UART, line parser, routing table and banks.
// Assumes an asynchronous serial line on rxd_i and a one-clock register port.
module matrix_serial_command_interpreter
  import matrix_cmd_pkg::*;
#(
  parameter int BIT_CYC_9600_P = BIT_CYC_9600,
  parameter int BIT_CYC_2400_P = BIT_CYC_2400,
  parameter int BIT_CYC_1200_P = BIT_CYC_1200,
  parameter int BIT_CYC_300_P  = BIT_CYC_300
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 rxd_i,
  input  wire logic [3:0]           reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [31:0]          reg_rdata_o,
  output logic                      txd_o,
  output logic      [NUM_OUT*4-1:0] route_o
);
  // Two-digit decimal decode: {valid, value}
  function automatic logic [7:0] dec2(input logic [7:0] a, input logic [7:0] b);
    logic ok;
    logic [6:0] v;
    ok = (a >= CH_ZERO) && (a <= CH_NINE) && (b >= CH_ZERO) && (b <= CH_NINE);
    v  = 7'({3'h0, a[3:0]} * 7'h0a + {3'h0, b[3:0]});
    return {ok, v};
  endfunction
  // Two-digit decimal encode of 0..19
  function automatic logic [15:0] enc2(input logic [4:0] v);
    if (v >= 5'h0a) return {8'h31, CH_ZERO + {3'h0, v - 5'h0a}};
    else return {CH_ZERO, CH_ZERO + {3'h0, v}};
  endfunction
  ctl_state_t st_r;                       // Controller state
  logic [1:0]  rate_r;                    // Selected line rate
  logic [3:0]  unit_addr_r;               // Own unit address
  logic        last_qm_r;                 // Last addressed reply was a question mark
  logic [19:0] bit_cyc;                   // Clocks per bit at current rate
  logic        rx_s1_r, rx_s2_r;          // Receive synchroniser
  logic [19:0] rx_cnt_r;                  // Receive bit timer
  logic [3:0]  rx_bit_r;                  // Receive bit position
  logic [7:0]  rx_sh_r;                   // Receive shifter
  logic        rx_busy_r;                 // Receiving a frame
  logic        rx_vld_r;                  // One-cycle byte strobe
  logic [7:0]  rx_byte_r;                 // Received byte
  logic [19:0] tx_cnt_r;                  // Transmit bit timer
  logic [3:0]  tx_bit_r;                  // Transmit bit position
  logic [8:0]  tx_sh_r;                   // Transmit shifter with stop bit
  logic        tx_busy_r;                 // Transmitting a frame
  logic        tx_go;                     // Launch next character
  logic [7:0]  tx_byte;                   // Character to launch
  logic [4:0]  tx_idx_r;                  // Position in echo plus reply
  logic [4:0]  tx_total_r;                // Echo plus reply length
  logic [7:0]  line_r [LINE_MAX];         // Received line, terminator excluded
  logic [4:0]  len_r;                     // Stored characters
  logic        ovf_r;                     // Line longer than buffer
  logic [7:0]  resp_r [RESP_MAX];         // Reply characters
  logic [3:0]  resp_len;                  // Reply length for current line
  logic [3:0]  route_r [NUM_OUT];         // Input index per output
  logic [3:0]  bank_r [NUM_BANK][NUM_OUT]; // Saved routing banks
  logic [15:0] cmd;                       // Command letter pair
  logic [7:0]  f1, f2, f3;                // Decoded numeric fields
  logic        known, mine, good, rate_hit, act;
  logic [15:0] q_digits;                  // Digits of queried input
  assign cmd = {line_r[0], line_r[1]};
  assign f1  = dec2(line_r[3], line_r[4]);
  assign f2  = dec2(line_r[6], line_r[7]);
  assign f3  = dec2(line_r[9], line_r[10]);
  assign q_digits = enc2({1'b0, route_r[f2[3:0] - 4'h1]} + 5'h01);
  // Bit period from the selected rate
  always_comb begin
    unique case (rate_r)
      RATE_9600: bit_cyc = 20'(BIT_CYC_9600_P);
      RATE_2400: bit_cyc = 20'(BIT_CYC_2400_P);
      RATE_1200: bit_cyc = 20'(BIT_CYC_1200_P);
      RATE_300:  bit_cyc = 20'(BIT_CYC_300_P);
    endcase
  end
  // Only the data line is sampled; no handshake pins exist
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else begin
      rx_s1_r <= rxd_i;
      rx_s2_r <= rx_s1_r;
    end
  end
  // Receiver: centre of start bit, then 8 data bits, then stop bit
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_cnt_r  <= 20'h0;
      rx_bit_r  <= 4'h0;
      rx_sh_r   <= 8'h0;
      rx_busy_r <= 1'b0;
      rx_vld_r  <= 1'b0;
      rx_byte_r <= 8'h0;
    end else begin
      rx_vld_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!rx_s2_r) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r  <= bit_cyc >> 1;
          rx_bit_r  <= 4'h0;
        end
      end else if (rx_cnt_r != 20'h0) begin
        rx_cnt_r <= rx_cnt_r - 20'h1;
      end else begin
        rx_cnt_r <= bit_cyc - 20'h1;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0) begin
          // Glitch shorter than half a bit is not a start
          if (rx_s2_r) rx_busy_r <= 1'b0;
        end else if (rx_bit_r <= 4'(DATA_BITS)) begin
          rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]};
        end else begin
          // A low stop bit is a framing error and the byte is dropped
          rx_busy_r <= 1'b0;
          rx_vld_r  <= rx_s2_r;
          rx_byte_r <= rx_sh_r;
        end
      end
    end
  end
  // Transmitter: start, 8 data bits LSB first, one stop bit
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      txd_o     <= 1'b1;
      tx_cnt_r  <= 20'h0;
      tx_bit_r  <= 4'h0;
      tx_sh_r   <= 9'h1ff;
      tx_busy_r <= 1'b0;
    end else if (!tx_busy_r) begin
      txd_o <= 1'b1;
      if (tx_go) begin
        tx_busy_r <= 1'b1;
        txd_o     <= 1'b0;
        tx_sh_r   <= {1'b1, tx_byte};
        tx_cnt_r  <= bit_cyc - 20'h1;
        tx_bit_r  <= 4'h0;
      end
    end else if (tx_cnt_r != 20'h0) begin
      tx_cnt_r <= tx_cnt_r - 20'h1;
    end else if (tx_bit_r == FRAME_LAST) begin
      tx_busy_r <= 1'b0;
    end else begin
      txd_o    <= tx_sh_r[0];
      tx_sh_r  <= {1'b1, tx_sh_r[8:1]};
      tx_bit_r <= tx_bit_r + 4'h1;
      tx_cnt_r <= bit_cyc - 20'h1;
    end
  end
  // Line buffer; characters past the end are dropped and flagged
  always_ff @(posedge sys_clk_i) begin
    if (st_r == ST_RX && rx_vld_r && rx_byte_r != CH_CR && len_r < 5'(LINE_MAX))
      line_r[len_r[3:0]] <= rx_byte_r;
  end
  // Decode of a terminated line
  always_comb begin
    known    = (len_r >= 5'h05) && (line_r[2] == CH_SP) &&
               (cmd inside {CMD_CONNECT_ONE, CMD_CONNECT_ALL, CMD_QUERY, CMD_SAVE,
                            CMD_RESTORE, CMD_RATE, CMD_RESTART, CMD_VERSION, CMD_DIMS});
    mine     = f1[7] && (f1[6:0] == {3'h0, unit_addr_r});
    good     = 1'b0;
    resp_len = 4'h2;
    if (len_r == 5'h08 && line_r[5] == CH_COMMA && f2[7]) begin
      unique case (cmd)
        CMD_CONNECT_ALL: good = (f2[6:0] != 7'h0) && (f2[6:0] <= 7'(NUM_IN));
        CMD_QUERY:       good = (f2[6:0] != 7'h0) && (f2[6:0] <= 7'(NUM_OUT));
        CMD_SAVE:        good = f2[6:0] < 7'(NUM_BANK);
        CMD_RESTORE:     good = f2[6:0] < 7'(NUM_BANK);
        CMD_RATE:        good = f2[6:0] inside {CODE_1200, CODE_2400, CODE_9600};
        CMD_VERSION:     good = f2[6:0] == 7'h0;
        default:         good = 1'b0;
      endcase
    end else if (len_r == 5'h0b && line_r[5] == CH_COMMA && line_r[8] == CH_COMMA) begin
      good = (cmd == CMD_CONNECT_ONE) && f2[7] && f3[7] && (f2[6:0] != 7'h0) &&
             (f2[6:0] <= 7'(NUM_IN)) && (f3[6:0] != 7'h0) && (f3[6:0] <= 7'(NUM_OUT));
    end else if (len_r == 5'h05) begin
      good = (cmd == CMD_RESTART) || (cmd == CMD_DIMS);
    end
    if (ovf_r) good = 1'b0;
    if (good && cmd inside {CMD_QUERY, CMD_SAVE, CMD_RESTORE}) resp_len = 4'h5;
    if (good && cmd == CMD_VERSION) resp_len = 4'h7;
    if (good && cmd == CMD_DIMS) resp_len = 4'h8;
    rate_hit = (st_r == ST_PARSE) && known && (cmd == CMD_RATE) && good &&
               f1[7] && (f1[6:0] == 7'h0);
    act      = (st_r == ST_PARSE) && known && mine && good && (cmd != CMD_RATE);
  end
  // Next character: echo, terminator, then reply
  always_comb begin
    tx_go = (st_r == ST_TX) && !tx_busy_r && (tx_idx_r < tx_total_r);
    if (tx_idx_r < len_r) tx_byte = line_r[tx_idx_r[3:0]];
    else if (tx_idx_r == len_r) tx_byte = CH_CR;
    else tx_byte = resp_r[3'(tx_idx_r - len_r - 5'h01)];
  end
  // Controller: collect, decide, then send echo and reply
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r       <= ST_RX;
      len_r      <= 5'h0;
      ovf_r      <= 1'b0;
      tx_idx_r   <= 5'h0;
      tx_total_r <= 5'h0;
      last_qm_r  <= 1'b0;
    end else begin
      unique case (st_r)
        ST_RX: if (rx_vld_r) begin
          if (rx_byte_r == CH_CR) st_r <= ST_PARSE;
          else if (len_r < 5'(LINE_MAX)) len_r <= len_r + 5'h01;
          else ovf_r <= 1'b1;
        end
        ST_PARSE: begin
          tx_idx_r <= 5'h0;
          if (known && mine && cmd != CMD_RATE) begin
            // Only the addressed unit talks on the shared line
            st_r       <= ST_TX;
            tx_total_r <= len_r + 5'h01 + {1'b0, resp_len};
            last_qm_r  <= !good;
          end else begin
            st_r  <= ST_RX;
            len_r <= 5'h0;
            ovf_r <= 1'b0;
          end
        end
        ST_TX: begin
          if (tx_go) tx_idx_r <= tx_idx_r + 5'h01;
          else if (!tx_busy_r && tx_idx_r == tx_total_r) begin
            st_r  <= ST_RX;
            len_r <= 5'h0;
            ovf_r <= 1'b0;
          end
        end
      endcase
    end
  end
  // Reply characters, captured while deciding
  always_ff @(posedge sys_clk_i) begin
    if (st_r == ST_PARSE) begin
      resp_r[0] <= good ? CH_STAR : CH_QM;
      resp_r[1] <= CH_CR;
      resp_r[2] <= line_r[6];
      resp_r[3] <= line_r[7];
      resp_r[4] <= CH_CR;
      resp_r[5] <= CH_NUL;
      resp_r[6] <= CH_CR;
      resp_r[7] <= CH_CR;
      if (cmd == CMD_QUERY) begin
        resp_r[2] <= q_digits[15:8];
        resp_r[3] <= q_digits[7:0];
      end else if (cmd == CMD_VERSION) begin
        resp_r[2] <= VERSION_TEXT[23:16];
        resp_r[3] <= VERSION_TEXT[15:8];
        resp_r[4] <= VERSION_TEXT[7:0];
      end else if (cmd == CMD_DIMS) begin
        {resp_r[2], resp_r[3]} <= enc2(5'(NUM_IN));
        resp_r[4] <= CH_COMMA;
        {resp_r[5], resp_r[6]} <= enc2(5'(NUM_OUT));
      end
    end
  end
  // Routing table and banks; reset gives output n from input n
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int o = 0; o < NUM_OUT; o++) begin
        route_r[o] <= 4'(o);
        for (int b = 0; b < NUM_BANK; b++) bank_r[b][o] <= 4'(o);
      end
    end else if (act) begin
      unique case (cmd)
        CMD_CONNECT_ONE: route_r[f3[3:0] - 4'h1] <= f2[3:0] - 4'h1;
        CMD_CONNECT_ALL: for (int o = 0; o < NUM_OUT; o++) route_r[o] <= f2[3:0] - 4'h1;
        CMD_SAVE:    for (int o = 0; o < NUM_OUT; o++) bank_r[f2[3:0]][o] <= route_r[o];
        CMD_RESTORE: for (int o = 0; o < NUM_OUT; o++) route_r[o] <= bank_r[f2[3:0]][o];
        CMD_RESTART: for (int o = 0; o < NUM_OUT; o++) route_r[o] <= bank_r[0][o];
        default: ;
      endcase
    end
  end
  // Flatten the routing table onto the output port
  always_comb begin
    for (int o = 0; o < NUM_OUT; o++) route_o[o*4 +: 4] = route_r[o];
  end
  // Configuration: the command rate change wins over a register write
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rate_r      <= RATE_9600;
      unit_addr_r <= ADDR_RST;
    end else begin
      if (reg_wr_i && reg_addr_i == REG_CFG) begin
        rate_r <= reg_wdata_i[CFG_RATE_LSB +: 2];
        // Address zero is reserved for broadcast and is refused
        if (reg_wdata_i[CFG_ADDR_LSB +: 4] != 4'h0)
          unit_addr_r <= reg_wdata_i[CFG_ADDR_LSB +: 4];
      end
      if (rate_hit) begin
        unique case (f2[6:0])
          CODE_1200: rate_r <= RATE_1200;
          CODE_2400: rate_r <= RATE_2400;
          default:   rate_r <= RATE_9600;
        endcase
      end
    end
  end
  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) reg_rdata_o <= 32'h0;
    else if (reg_rd_i && reg_addr_i == REG_CFG)
      reg_rdata_o <= {26'h0, rate_r, unit_addr_r};
    else if (reg_rd_i && reg_addr_i == REG_STAT)
      reg_rdata_o <= {30'h0, last_qm_r, st_r != ST_RX};
    else reg_rdata_o <= 32'h0;
  end
endmodule

// File: verif/matrix_cmd_props.sv
// Port checker for the serial command interpreter.
// Assumes one clock domain and the active-low asynchronous reset.
module matrix_cmd_props
  import matrix_cmd_pkg::*;
(
  input wire logic                 sys_clk_i,
  input wire logic                 arst_n_i,
  input wire logic                 rxd_i,
  input wire logic [3:0]           reg_addr_i,
  input wire logic [31:0]          reg_wdata_i,
  input wire logic                 reg_wr_i,
  input wire logic                 reg_rd_i,
  input wire logic [31:0]          reg_rdata_o,
  input wire logic                 txd_o,
  input wire logic [NUM_OUT*4-1:0] route_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Reset values hold even while reset is low, so no disable here
  a_reset_state_ok: assert property (@(posedge sys_clk_i) disable iff (1'b0)
    !arst_n_i |-> txd_o && route_o == 64'hfedcba9876543210)
    else $error("reset state wrong");
  a_rdata_one_cycle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside read cycle");
  a_unmapped_reads_zero: assert property (reg_rd_i && reg_addr_i != REG_CFG &&
    reg_addr_i != REG_STAT |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");
  a_cfg_high_zero: assert property (reg_rd_i && reg_addr_i == REG_CFG |=>
    reg_rdata_o[31:6] == '0 && reg_rdata_o[3:0] != 4'h0)
    else $error("config read malformed");
  a_stat_high_zero: assert property (reg_rd_i && reg_addr_i == REG_STAT |=>
    reg_rdata_o[31:2] == '0)
    else $error("status read malformed");
  // A config write with a legal address reads back two cycles later
  a_cfg_write_back: assert property (reg_wr_i && reg_addr_i == REG_CFG &&
    reg_wdata_i[3:0] != 4'h0 ##2 reg_rd_i && reg_addr_i == REG_CFG |=>
    reg_rdata_o[5:0] == $past(reg_wdata_i[5:0], 3))
    else $error("config write not read back");
  // Fastest rate has at least eight clocks per bit
  a_start_bit_len: assert property ($fell(txd_o) |-> !txd_o [*8])
    else $error("start bit too short");
  // Transmission only begins while the host line is idle
  a_tx_after_line: assert property ($fell(txd_o) |-> $past(rxd_i) && $past(rxd_i, 2))
    else $error("transmit while host sends");
  // Routing only moves after a completed line, with the stop bit seen
  a_route_cause: assert property ($changed(route_o) |->
    $past(rxd_i, 3) && $past(rxd_i, 4))
    else $error("routing changed without a line");
  c_cfg_write: cover property (reg_wr_i && reg_addr_i == REG_CFG);
  c_tx_frame: cover property ($fell(txd_o));
  c_route_move: cover property ($changed(route_o));
endmodule

bind matrix_serial_command_interpreter matrix_cmd_props u_props (
  .sys_clk_i  (sys_clk_i),
  .arst_n_i   (arst_n_i),
  .rxd_i      (rxd_i),
  .reg_addr_i (reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i   (reg_wr_i),
  .reg_rd_i   (reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .txd_o      (txd_o),
  .route_o    (route_o)
);

// File: verif/host_uart_model.sv
// Host side of the serial link: sends command lines, collects replies.
// Assumes the bench sets the bit length to match the device's rate.
module host_uart_model (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] bit_cyc_i,
  input  wire logic       txd_i,
  output logic            rxd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx_q[$];  // Bytes received from the device
  initial rxd_o = 1'b1;  // Idle high between lines
  // Whole line in one burst, no gaps; must be entered just after an edge
  task automatic send_line(input string s);
    logic [7:0] ch;
    for (int i = 0; i <= s.len(); i++) begin
      ch = (i == s.len()) ? 8'h0d : s[i];
      for (int b = 0; b < 10; b++) begin
        rxd_o <= (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : ch[b-1];
        repeat (bit_cyc_i) @(posedge sys_clk_i);
      end
    end
  endtask
  // Mid-bit sampler; a bad stop bit drops the byte
  initial begin
    logic [7:0] d;
    forever begin
      @(negedge txd_i);
      repeat (bit_cyc_i / 2) @(posedge sys_clk_i);
      for (int b = 0; b < 8; b++) begin
        repeat (bit_cyc_i) @(posedge sys_clk_i);
        d[b] = txd_i;
      end
      repeat (bit_cyc_i) @(posedge sys_clk_i);
      if (txd_i === 1'b1) rx_q.push_back(d);
    end
  end
endmodule

// File: verif/tb_top.sv
// Bench top: clock, reset, register tasks and one task per test.
// Assumes the host model on the serial line and the bound checker.
module tb_top
  import matrix_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0;
  logic        arst_n  = 1'b1;  // Pulled low at time zero so the reset edge is seen
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr  = 1'b0;
  logic        reg_rd  = 1'b0;
  logic [31:0] reg_rdata;
  logic        txd;
  logic        rxd;
  logic [63:0] route;
  logic [7:0]  bit_cyc = 8'h08;  // Host bit length, follows the device rate
  logic [63:0] exp_route = 64'hfedcba9876543210;
  logic [31:0] rd_val;
  int          mismatches = 0;
  int          check_count = 0;
  int          cyc = 0;
  initial forever #2.5 sys_clk = ~sys_clk;
  // Short bit times keep the run far below the cycle ceiling
  matrix_serial_command_interpreter #(.BIT_CYC_9600_P(8), .BIT_CYC_2400_P(16),
    .BIT_CYC_1200_P(24), .BIT_CYC_300_P(32)) dut (.sys_clk_i(sys_clk),
    .arst_n_i(arst_n), .rxd_i(rxd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .txd_o(txd),
    .route_o(route));
  host_uart_model host (.sys_clk_i(sys_clk), .bit_cyc_i(bit_cyc), .txd_i(txd), .rxd_o(rxd));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Send a line; expect echo plus reply, or total silence
  task automatic do_cmd(input string line, input string resp, input bit heard);
    string exp;
    exp = heard ? {line, "\r", resp} : "";
    host.rx_q.delete();
    @(posedge sys_clk);
    host.send_line(line);
    for (int n = 0; n < 400 * bit_cyc && host.rx_q.size() < exp.len(); n++)
      @(posedge sys_clk);
    // Three more character times to catch stray bytes
    repeat (30 * bit_cyc) @(posedge sys_clk);
    chk({"reply length ", line}, exp.len(), host.rx_q.size());
    // A tilde stands for the NUL byte, which a string cannot carry
    for (int i = 0; i < exp.len() && i < host.rx_q.size(); i++)
      chk({"reply byte ", line}, (exp[i] == "~") ? 8'h00 : exp[i], host.rx_q[i]);
  endtask
  task automatic t_reset();
    chk("txd idle", 1, txd);
    chk("route reset", exp_route, route);
    reg_read(REG_CFG, rd_val);
    chk("cfg reset", 32'h1, rd_val);
    reg_read(REG_STAT, rd_val);
    chk("stat reset", 0, rd_val);
    reg_read(4'h8, rd_val);
    chk("unmapped read", 0, rd_val);
    $display("test reset done");
  endtask
  task automatic t_route();
    do_cmd("CS 01,05,03", "*\r", 1);
    exp_route[11:8] = 4'h4;
    chk("route one", exp_route, route);
    do_cmd("RO 01,03", "*\r05\r", 1);
    do_cmd("CC 01,02", "*\r02\r", 1);
    do_cmd("CA 01,07", "*\r", 1);
    chk("route all", {16{4'h6}}, route);
    do_cmd("RC 01,02", "*\r02\r", 1);
    chk("route bank", exp_route, route);
    $display("test routing done");
  endtask
  task automatic t_filter();
    do_cmd("CS 02,01,01", "", 0);
    do_cmd("XX 01", "", 0);
    chk("route kept", exp_route, route);
    do_cmd("CS 01,AB,01", "?\r", 1);
    reg_read(REG_STAT, rd_val);
    chk("stat bad line", 32'h2, rd_val);
    do_cmd("RU 01", "*\r16,16\r", 1);
    do_cmd("RV 01,00", string'({"*\r", VERSION_TEXT, "~\r"}), 1);
    do_cmd("RS 01", "*\r", 1);
    chk("route restart", 64'hfedcba9876543210, route);
    $display("test filter done");
  endtask
  task automatic t_rate();
    string      code[3] = '{"24", "12", "96"};
    logic [1:0] sel[3] = '{RATE_2400, RATE_1200, RATE_9600};
    logic [7:0] bc[3] = '{8'h10, 8'h18, 8'h08};
    for (int k = 0; k < 3; k++) begin
      do_cmd({"CB 00,", code[k]}, "", 0);
      bit_cyc <= bc[k];
      reg_read(REG_CFG, rd_val);
      chk("rate code", {26'h0, sel[k], 4'h1}, rd_val);
      do_cmd("RU 01", "*\r16,16\r", 1);
    end
    // A rate code outside the three command rate codes leaves the line rate alone
    do_cmd("CB 00,48", "", 0);
    reg_read(REG_CFG, rd_val);
    chk("rate 4800 refused", {26'h0, RATE_9600, 4'h1}, rd_val);
    reg_write(REG_CFG, {26'h0, RATE_300, 4'h5});
    bit_cyc <= 8'h20;
    do_cmd("RU 01", "", 0);
    do_cmd("RU 05", "*\r16,16\r", 1);
    reg_write(REG_CFG, 32'h0);
    reg_read(REG_CFG, rd_val);
    chk("zero address kept", 32'h5, rd_val);
    bit_cyc <= 8'h08;
    reg_write(REG_CFG, 32'h1);
    reg_read(REG_CFG, rd_val);
    chk("cfg restored", 32'h1, rd_val);
    $display("test rate done");
  endtask
  initial begin
    // Falls once every process waits on it, well before the first clock edge
    arst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_route();
    t_filter();
    t_rate();
    end_sim();
  end
endmodule
